/* hw/pcsi_pkg.sv */
// Purpose: shared constants and carriers of the program counter block
// Assumes: one CPU clock; execution logic issues one command a cycle
// Notes: register offsets are byte addresses on the register bus
package pcsi_pkg;
   // widths
   localparam int PC_W = 13;
   localparam int LOW_W = 8;
   localparam int LATH_W = 5;
   localparam int JMP_W = 11;
   localparam int STK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam int PTR_W = 8;
   localparam int FILE_W = 7;
   localparam int BANK_W = 2;
   localparam int EA_W = 9;
   localparam int WB_AW = 8;
   localparam int WB_DW = 32;
   // latch bits that feed the two top pc bits on jumps
   localparam int JMP_HI_W = 2;
   // reset values and vectors
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
   localparam logic [LATH_W-1:0] LATH_RST = 5'h00;
   localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
   localparam logic IBANK_RST = 1'b0;
   localparam logic [SP_W-1:0] SP_RST = 3'h0;
   localparam logic [SP_W-1:0] SP_ONE = 3'h1;
   // file address that selects indirect access
   localparam logic [FILE_W-1:0] IDP_ADDR = 7'h00;
   // register offsets
   localparam logic [WB_AW-1:0] REG_PC_LOW = 8'h00;
   localparam logic [WB_AW-1:0] REG_PC_LATCH = 8'h04;
   localparam logic [WB_AW-1:0] REG_PTR = 8'h08;
   localparam logic [WB_AW-1:0] REG_BANK = 8'h0C;
   localparam int IBANK_BIT = 0;
   // commands from the execution logic
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_STEP = 4'h1,
      OP_ABS_JUMP = 4'h2,
      OP_SUB_JUMP = 4'h3,
      OP_SUB_EXIT = 4'h4,
      OP_LIT_EXIT = 4'h5,
      OP_INT_EXIT = 4'h6,
      OP_IRQ = 4'h7,
      OP_PC_LOW_WR = 4'h8
   } pcsi_op_t;
   typedef struct packed {
      pcsi_op_t op;
      logic [JMP_W-1:0] target;
      logic [LOW_W-1:0] result;
   } pcsi_cmd_t;
   // data file access request and its resolved form
   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [FILE_W-1:0] addr;
      logic rd;
      logic wr;
   } pcsi_facc_t;
   typedef struct packed {
      logic [EA_W-1:0] addr;
      logic rd;
      logic wr;
      logic rd_zero;
   } pcsi_dacc_t;
endpackage

/* hw/pcsi_stack.sv */
// Purpose: eight-entry circular return address stack
// Assumes: push and pop never asked in the same cycle
// Notes: pointer hidden from software; no overflow or underflow flag
`timescale 1ns/100ps
`default_nettype none
module pcsi_stack (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // requests
   input wire logic push,
   input wire logic pop,
   input wire logic [pcsi_pkg::PC_W-1:0] push_pc,
   // newest entry
   output logic [pcsi_pkg::PC_W-1:0] top_pc
);
   import pcsi_pkg::*;

   logic [PC_W-1:0] mem_ff [STK_DEPTH];
   logic [SP_W-1:0] sp_ff;
   logic [SP_W-1:0] nxt_sp;
   wire logic [SP_W-1:0] sp_last;

   // pointer wraps modulo eight both ways, silently
   assign sp_last = sp_ff - SP_ONE;
   assign nxt_sp = push ? sp_ff + SP_ONE : (pop ? sp_last : sp_ff);
   assign top_pc = mem_ff[sp_last];

   // pointer register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sp_ff <= SP_RST;
      end else begin
         sp_ff <= nxt_sp;
      end
   end

   // ninth push lands on the slot of the first
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[sp_ff] <= push_pc;
      end
   end

   a_push_top: assert property (
      @(posedge clk) disable iff (rst)
      push |=> top_pc == $past(push_pc))
      else $error("pushed value not on top");

   a_pop_wrap: assert property (
      @(posedge clk) disable iff (rst)
      push ##1 (pop && !push) |=> sp_ff == $past(sp_ff, 2))
      else $error("pop did not undo push");
endmodule
`default_nettype wire

/* hw/pcsi_indirect.sv */
// Purpose: resolves a data file access, direct or through the pointer
// Assumes: pointer and bank bit are stable registers of the caller
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module pcsi_indirect (
   // request
   input wire pcsi_pkg::pcsi_facc_t facc,
   // pointer state
   input wire logic [pcsi_pkg::PTR_W-1:0] ptr,
   input wire logic ibank,
   // resolved access
   output pcsi_pkg::pcsi_dacc_t dacc
);
   import pcsi_pkg::*;

   wire logic is_ind;
   wire logic self_ref;
   wire logic [EA_W-1:0] ea_ind;
   wire logic [EA_W-1:0] ea_dir;

   // port address has no storage, it redirects
   assign is_ind = facc.addr == IDP_ADDR;
   assign ea_ind = {ibank, ptr};
   assign ea_dir = {facc.bank, facc.addr};
   // pointer aimed back at the port itself
   assign self_ref = is_ind && (ptr[FILE_W-1:0] == IDP_ADDR);

   // self reference reads zero and stores nothing
   assign dacc.addr = is_ind ? ea_ind : ea_dir;
   assign dacc.rd = facc.rd;
   assign dacc.wr = facc.wr && !self_ref;
   assign dacc.rd_zero = facc.rd && self_ref;
endmodule
`default_nettype wire

/* hw/pcsi_top.sv */
// Purpose: program counter, return stack and indirect addressing
// Assumes: execution logic on CLK issues one command per cycle
// Notes: registers on classic wishbone, one aligned word each
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - 13-bit pc, low byte readable and writable
// - upper pc bits hidden, loaded from latch
// - every reset clears the whole pc
// - low byte write loads latch bits 4:0
// - jumps take top two bits from latch
// - low byte wrap never carries into latch
// - eight 13-bit entries, hidden pointer
// - subroutine jump and interrupt push pc
// - three exit kinds pop into pc
// - push and pop leave latch alone
// - circular stack, ninth push overwrites first
// - no overflow or underflow status
// - port address accesses pointer target
// - port read through itself gives zero
// - port write through itself stores nothing
// - address is bank bit over pointer
module pcsi_top (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [pcsi_pkg::WB_AW-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [pcsi_pkg::WB_DW-1:0] WB_DAT_I,
   output logic [pcsi_pkg::WB_DW-1:0] WB_DAT_O,
   output logic WB_ACK_O,
   // execution commands
   input wire pcsi_pkg::pcsi_cmd_t EXE_CMD,
   input wire pcsi_pkg::pcsi_facc_t EXE_FACC,
   // fetch address and resolved data access
   output logic [pcsi_pkg::PC_W-1:0] PC_FETCH,
   output pcsi_pkg::pcsi_dacc_t DATA_ACC
);
   import pcsi_pkg::*;

   // state
   logic [PC_W-1:0] pc_ff;
   logic [PC_W-1:0] nxt_pc;
   logic [LATH_W-1:0] lath_ff;
   logic [PTR_W-1:0] ptr_ff;
   logic ibank_ff;
   logic ack_ff;
   logic [WB_DW-1:0] dat_ff;
   logic [WB_DW-1:0] nxt_dat;
   pcsi_dacc_t dacc_ff;

   // wires
   wire logic bus_req;
   wire logic hit_low;
   wire logic hit_lath;
   wire logic hit_ptr;
   wire logic hit_bank;
   wire logic exe_busy;
   wire logic bus_hold;
   wire logic bus_take;
   wire logic bus_wr;
   wire logic wr_low;
   wire logic wr_lath;
   wire logic wr_ptr;
   wire logic wr_bank;
   wire logic op_push;
   wire logic op_pop;
   wire logic [PC_W-1:0] pc_inc;
   wire logic [PC_W-1:0] push_pc;
   wire logic [PC_W-1:0] stk_top;
   wire logic [PC_W-1:0] pc_jump;
   wire logic [PC_W-1:0] pc_exe_low;
   wire logic [PC_W-1:0] pc_bus_low;
   wire pcsi_dacc_t dacc;

   // bus request and address decode
   assign bus_req = WB_CYC_I && WB_STB_I && !ack_ff;
   assign hit_low = WB_ADR_I == REG_PC_LOW;
   assign hit_lath = WB_ADR_I == REG_PC_LATCH;
   assign hit_ptr = WB_ADR_I == REG_PTR;
   assign hit_bank = WB_ADR_I == REG_BANK;

   // a bus low byte write waits while a command owns the pc
   assign exe_busy = EXE_CMD.op != OP_NONE;
   assign bus_hold = hit_low && WB_WE_I && exe_busy;
   assign bus_take = bus_req && !bus_hold;
   assign bus_wr = bus_take && WB_WE_I && WB_SEL_I[0];
   assign wr_low = bus_wr && hit_low;
   assign wr_lath = bus_wr && hit_lath;
   assign wr_ptr = bus_wr && hit_ptr;
   assign wr_bank = bus_wr && hit_bank;

   // stack requests from commands
   assign op_push = (EXE_CMD.op == OP_SUB_JUMP)
      || (EXE_CMD.op == OP_IRQ);
   assign op_pop = (EXE_CMD.op == OP_SUB_EXIT)
      || (EXE_CMD.op == OP_LIT_EXIT)
      || (EXE_CMD.op == OP_INT_EXIT);

   // candidate pc values
   assign pc_inc = pc_ff + PC_ONE;
   // interrupt resumes the interrupted address, a call the next one
   assign push_pc = (EXE_CMD.op == OP_IRQ) ? pc_ff : pc_inc;
   assign pc_jump = {lath_ff[LATH_W-1 -: JMP_HI_W], EXE_CMD.target};
   // whole latch joins the written low byte; sums wrap in 8 bits
   assign pc_exe_low = {lath_ff, EXE_CMD.result};
   assign pc_bus_low = {lath_ff, WB_DAT_I[LOW_W-1:0]};

   // next program counter
   always_comb begin
      case (EXE_CMD.op)
         OP_STEP: begin
            nxt_pc = pc_inc;
         end
         OP_ABS_JUMP, OP_SUB_JUMP: begin
            nxt_pc = pc_jump;
         end
         OP_SUB_EXIT, OP_LIT_EXIT, OP_INT_EXIT: begin
            nxt_pc = stk_top;
         end
         OP_IRQ: begin
            nxt_pc = IRQ_VECTOR;
         end
         OP_PC_LOW_WR: begin
            nxt_pc = pc_exe_low;
         end
         default: begin
            nxt_pc = wr_low ? pc_bus_low : pc_ff;
         end
      endcase
   end

   // program counter, cleared by every reset
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pc_ff <= PC_RST;
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   // latch changes only by software write
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         lath_ff <= LATH_RST;
      end else if (wr_lath) begin
         lath_ff <= WB_DAT_I[LATH_W-1:0];
      end
   end

   // pointer and bank bit for indirect access
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ptr_ff <= PTR_RST;
         ibank_ff <= IBANK_RST;
      end else begin
         if (wr_ptr) begin
            ptr_ff <= WB_DAT_I[PTR_W-1:0];
         end
         if (wr_bank) begin
            ibank_ff <= WB_DAT_I[IBANK_BIT];
         end
      end
   end

   // read mux; only the low pc byte is visible
   always_comb begin
      nxt_dat = '0;
      if (hit_low) begin
         nxt_dat[LOW_W-1:0] = pc_ff[LOW_W-1:0];
      end else if (hit_lath) begin
         nxt_dat[LATH_W-1:0] = lath_ff;
      end else if (hit_ptr) begin
         nxt_dat[PTR_W-1:0] = ptr_ff;
      end else if (hit_bank) begin
         nxt_dat[IBANK_BIT] = ibank_ff;
      end
   end

   // one-cycle acknowledge, unmapped reads give zero
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ack_ff <= 1'b0;
         dat_ff <= '0;
      end else begin
         ack_ff <= bus_take;
         dat_ff <= bus_take ? nxt_dat : '0;
      end
   end

   // return stack, no status of wrap at all
   pcsi_stack u_stack (
      .clk(CLK),
      .rst(RST),
      .push(op_push),
      .pop(op_pop),
      .push_pc(push_pc),
      .top_pc(stk_top)
   );

   // data access resolution
   pcsi_indirect u_ind (
      .facc(EXE_FACC),
      .ptr(ptr_ff),
      .ibank(ibank_ff),
      .dacc(dacc)
   );

   // resolved access registered for the data file
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dacc_ff <= '0;
      end else begin
         dacc_ff <= dacc;
      end
   end

   // outputs
   assign PC_FETCH = pc_ff;
   assign DATA_ACC = dacc_ff;
   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = dat_ff;

   // multi-step sequences
   sequence s_call_back;
      (EXE_CMD.op == OP_SUB_JUMP) ##1 (EXE_CMD.op == OP_SUB_EXIT);
   endsequence

   sequence s_irq_back;
      (EXE_CMD.op == OP_IRQ) ##1 (EXE_CMD.op == OP_INT_EXIT);
   endsequence

   a_reset_pc: assert property (
      @(posedge CLK) disable iff (RST)
      $past(RST) |-> pc_ff == PC_RST)
      else $error("pc not clear after reset");

   a_low_load: assert property (
      @(posedge CLK) disable iff (RST)
      EXE_CMD.op == OP_PC_LOW_WR
      |=> pc_ff == {$past(lath_ff), $past(EXE_CMD.result)})
      else $error("low byte write did not load whole pc");

   a_jump_top: assert property (
      @(posedge CLK) disable iff (RST)
      (EXE_CMD.op == OP_ABS_JUMP) || (EXE_CMD.op == OP_SUB_JUMP)
      |=> pc_ff[PC_W-1 -: JMP_HI_W] == $past(lath_ff[LATH_W-1 -: JMP_HI_W])
      && pc_ff[JMP_W-1:0] == $past(EXE_CMD.target))
      else $error("jump pc bits wrong");

   a_no_carry: assert property (
      @(posedge CLK) disable iff (RST)
      (EXE_CMD.op == OP_PC_LOW_WR) && !wr_lath |=> $stable(lath_ff))
      else $error("latch moved on low byte write");

   a_call_back: assert property (
      @(posedge CLK) disable iff (RST)
      s_call_back |=> pc_ff == $past(pc_ff, 2) + PC_ONE)
      else $error("return address not after call");

   a_irq_back: assert property (
      @(posedge CLK) disable iff (RST)
      s_irq_back |=> pc_ff == $past(pc_ff, 2))
      else $error("interrupt exit did not resume");

   a_latch_keep: assert property (
      @(posedge CLK) disable iff (RST)
      (op_push || op_pop) && !wr_lath |=> $stable(lath_ff))
      else $error("latch changed by stack");

   a_ind_zero: assert property (
      @(posedge CLK) disable iff (RST)
      EXE_FACC.rd && EXE_FACC.addr == IDP_ADDR
      && ptr_ff[FILE_W-1:0] == IDP_ADDR |=> DATA_ACC.rd_zero)
      else $error("self indirect read not zero");

   a_ind_nowr: assert property (
      @(posedge CLK) disable iff (RST)
      EXE_FACC.addr == IDP_ADDR
      && ptr_ff[FILE_W-1:0] == IDP_ADDR |=> !DATA_ACC.wr)
      else $error("self indirect write stored");

   a_ind_addr: assert property (
      @(posedge CLK) disable iff (RST)
      EXE_FACC.addr == IDP_ADDR
      |=> DATA_ACC.addr == {$past(ibank_ff), $past(ptr_ff)})
      else $error("indirect address wrong");

   a_bus_ack: assert property (
      @(posedge CLK) disable iff (RST)
      bus_req && !bus_hold |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("bus acknowledge not one cycle");

   a_irq_entry: assert property (
      @(posedge CLK) disable iff (RST)
      EXE_CMD.op == OP_IRQ |=> pc_ff == IRQ_VECTOR)
      else $error("interrupt did not vector");

   a_step_next: assert property (
      @(posedge CLK) disable iff (RST)
      EXE_CMD.op == OP_STEP |=> pc_ff == $past(pc_ff) + PC_ONE)
      else $error("step did not advance pc");

   a_bus_hold: assert property (
      @(posedge CLK) disable iff (RST)
      bus_req && bus_hold |=> !WB_ACK_O)
      else $error("low byte write taken under command");
endmodule
`default_nettype wire

/* dv/pcsi_top_tb.sv */
// Purpose: self-checking bench of the program counter, stack and indirect block
// Assumes: registers over classic wishbone; one command at a time from the bench
// Notes: no random stimulus; a cycle ceiling cuts any hang short
`timescale 1ns/100ps
`default_nettype none
module pcsi_top_tb;
   import pcsi_pkg::*;
   localparam int MAX_CYC = 20000;
   logic clk;
   logic rst;
   logic cyc;
   logic stb;
   logic we;
   logic [WB_AW-1:0] adr;
   logic [3:0] sel;
   logic [WB_DW-1:0] dat_w;
   logic [WB_DW-1:0] dat_r;
   logic ack;
   pcsi_cmd_t cmd;
   pcsi_facc_t facc;
   logic [PC_W-1:0] pc;
   pcsi_dacc_t dacc;
   logic [WB_DW-1:0] rd_q;
   int n_mismatch;
   int tests_run;
   int n_cyc;

   // block under test
   pcsi_top i_pcsi_top (
      .CLK(clk),
      .RST(rst),
      .WB_CYC_I(cyc),
      .WB_STB_I(stb),
      .WB_WE_I(we),
      .WB_ADR_I(adr),
      .WB_SEL_I(sel),
      .WB_DAT_I(dat_w),
      .WB_DAT_O(dat_r),
      .WB_ACK_O(ack),
      .EXE_CMD(cmd),
      .EXE_FACC(facc),
      .PC_FETCH(pc),
      .DATA_ACC(dacc)
   );

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic end_of_test();
      $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= 4'hF;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      rd_q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd_chk(input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      chk(rd_q, exp);
   endtask

   // one command, then idle, then the fetch address is judged
   task automatic op(input pcsi_op_t o, input logic [JMP_W-1:0] t, input logic [LOW_W-1:0] r,
         input logic [PC_W-1:0] exp);
      @(posedge clk);
      cmd <= {o, t, r};
      @(posedge clk);
      cmd <= {OP_NONE, 11'h000, 8'h00};
      @(negedge clk);
      chk({19'h0, pc}, {19'h0, exp});
   endtask

   // one data access request, resolved form judged a cycle later
   task automatic acc(input logic [BANK_W-1:0] b, input logic [FILE_W-1:0] a, input logic r,
         input logic w, input logic [EA_W+2:0] exp);
      @(posedge clk);
      facc <= {b, a, r, w};
      @(posedge clk);
      facc <= '0;
      @(negedge clk);
      chk({20'h0, dacc}, {20'h0, exp});
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({19'h0, pc}, 32'h0000_0000);
      @(posedge clk);
      rst <= 1'b0;
   endtask

   // reset values, unmapped place
   task automatic t_reset_vals();
      chk({19'h0, pc}, 32'h0000_0000);
      rd_chk(REG_PC_LOW, 32'h0000_0000);
      rd_chk(REG_PC_LATCH, 32'h0000_0000);
      rd_chk(REG_PTR, 32'h0000_0000);
      rd_chk(REG_BANK, 32'h0000_0000);
      wb(1'b1, 8'h10, 32'h0000_00AA);
      rd_chk(8'h10, 32'h0000_0000);
   endtask

   // low byte write, step to 15FF, latch kept on low byte write, jumps
   task automatic t_pc_load();
      wb(1'b1, REG_PC_LATCH, 32'h0000_0015);
      wb(1'b1, REG_PC_LOW, 32'h0000_00FE);
      @(negedge clk);
      chk({19'h0, pc}, 32'h0000_15FE);
      rd_chk(REG_PC_LOW, 32'h0000_00FE);
      op(OP_STEP, 11'h000, 8'h00, 13'h15FF);
      op(OP_PC_LOW_WR, 11'h000, 8'h03, 13'h1503);
      rd_chk(REG_PC_LATCH, 32'h0000_0015);
      op(OP_ABS_JUMP, 11'h7AB, 8'h00, 13'h17AB);
      wb(1'b1, REG_PC_LATCH, 32'h0000_000F);
      op(OP_ABS_JUMP, 11'h7AB, 8'h00, 13'h0FAB);
   endtask

   // bus low byte write waits while a command is present
   task automatic t_stall();
      wb(1'b1, REG_PC_LATCH, 32'h0000_000A);
      @(posedge clk);
      cmd <= {OP_STEP, 11'h000, 8'h00};
      fork
         wb(1'b1, REG_PC_LOW, 32'h0000_0033);
         begin
            repeat (4) @(posedge clk);
            chk({31'h0, ack}, 32'h0000_0000);
            cmd <= {OP_NONE, 11'h000, 8'h00};
         end
      join
      @(negedge clk);
      chk({19'h0, pc}, 32'h0000_0A33);
   endtask

   // nine calls, nine exits, then interrupt entry and exit
   task automatic t_stack();
      pcsi_op_t ex[3];
      logic [PC_W-1:0] e;
      int k;
      ex[0] = OP_SUB_EXIT;
      ex[1] = OP_LIT_EXIT;
      ex[2] = OP_INT_EXIT;
      wb(1'b1, REG_PC_LATCH, 32'h0000_0008);
      for (int i = 0; i < 9; i++) begin
         op(OP_SUB_JUMP, JMP_W'(i * 16), 8'h00, 13'h0800 | PC_W'(i * 16));
      end
      for (int j = 1; j < 10; j++) begin
         k = (j < 9) ? 9 - j : 8;
         e = 13'h0801 + PC_W'((k - 1) * 16);
         op(ex[j % 3], 11'h000, 8'h00, e);
      end
      rd_chk(REG_PC_LATCH, 32'h0000_0008);
      op(OP_IRQ, 11'h000, 8'h00, IRQ_VECTOR);
      op(OP_INT_EXIT, 11'h000, 8'h00, 13'h0871);
   endtask

   // call then exit, interrupt then exit, on back-to-back edges
   task automatic t_back();
      @(posedge clk);
      cmd <= {OP_SUB_JUMP, 11'h123, 8'h00};
      @(posedge clk);
      cmd <= {OP_SUB_EXIT, 11'h000, 8'h00};
      @(negedge clk);
      chk({19'h0, pc}, 32'h0000_0923);
      @(posedge clk);
      cmd <= {OP_IRQ, 11'h000, 8'h00};
      @(negedge clk);
      chk({19'h0, pc}, 32'h0000_0872);
      @(posedge clk);
      cmd <= {OP_INT_EXIT, 11'h000, 8'h00};
      @(negedge clk);
      chk({19'h0, pc}, {19'h0, IRQ_VECTOR});
      @(posedge clk);
      cmd <= {OP_NONE, 11'h000, 8'h00};
      @(negedge clk);
      chk({19'h0, pc}, 32'h0000_0872);
   endtask

   // indirect and direct data addressing
   task automatic t_indirect();
      wb(1'b1, REG_PTR, 32'h0000_0045);
      wb(1'b1, REG_BANK, 32'h0000_0001);
      acc(2'h0, 7'h00, 1'b1, 1'b0, {9'h145, 3'h4});
      wb(1'b1, REG_PTR, 32'h0000_0081);
      wb(1'b1, REG_BANK, 32'h0000_0000);
      acc(2'h0, 7'h00, 1'b0, 1'b1, {9'h081, 3'h2});
      wb(1'b1, REG_PTR, 32'h0000_0080);
      acc(2'h0, 7'h00, 1'b1, 1'b0, {9'h080, 3'h5});
      acc(2'h0, 7'h00, 1'b0, 1'b1, {9'h080, 3'h0});
      acc(2'h2, 7'h12, 1'b1, 1'b0, {9'h112, 3'h4});
   endtask

   // cycle ceiling
   always @(posedge clk) begin
      n_cyc <= n_cyc + 1;
      if (n_cyc == MAX_CYC) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // main sequence
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat_w = 32'h0000_0000;
      cmd = {OP_NONE, 11'h000, 8'h00};
      facc = '0;
      n_mismatch = 0;
      tests_run = 0;
      n_cyc = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset_vals();
      t_pc_load();
      t_stall();
      t_stack();
      t_back();
      t_indirect();
      do_reset();
      rd_chk(REG_PC_LATCH, 32'h0000_0000);
      end_of_test();
   end
endmodule
`default_nettype wire
